// ### ssf_pkg.sv
`default_nettype none
// Shared constants and carriers of the serial status flag block
package ssf_pkg;

  // Register byte offsets on the Wishbone port
  localparam int           ADR_W        = 4;
  localparam logic [3:0]   ADR_STATUS   = 4'h0;
  localparam logic [3:0]   ADR_CTRL     = 4'h4;
  localparam logic [3:0]   ADR_RXDATA   = 4'h8;
  localparam logic [3:0]   ADR_TXDATA   = 4'hC;

  // Bus data width and the byte lane that carries every register
  localparam int           WB_DW        = 32;
  localparam int           LANE0        = 0;

  // Initial values
  localparam logic [7:0]   STATUS_RESET = 8'h84;
  localparam logic [7:0]   CTRL_RESET   = 8'h00;
  localparam logic [7:0]   DATA_RESET   = 8'h00;

  // Status bit positions
  localparam int           BIT_TXE      = 7;
  localparam int           BIT_RXF      = 6;
  localparam int           BIT_OVR      = 5;
  localparam int           BIT_FER      = 4;
  localparam int           BIT_PER      = 3;
  localparam int           BIT_TX_COMPLETE     = 2;
  localparam int           BIT_MPB      = 1;
  localparam int           BIT_MULTIPROC_BIT_TO_SEND     = 0;

  // Clearable flags form a vector indexed from the lowest one upward
  localparam int           NFLAG        = 5;
  localparam int           FLAG_LSB     = BIT_PER;
  localparam int           F_PER        = BIT_PER - FLAG_LSB;
  localparam int           F_FER        = BIT_FER - FLAG_LSB;
  localparam int           F_OVR        = BIT_OVR - FLAG_LSB;
  localparam int           F_RXF        = BIT_RXF - FLAG_LSB;
  localparam int           F_TXE        = BIT_TXE - FLAG_LSB;

  // Control register layout, bit 7 reserved and read as zero
  typedef struct packed {
    logic rsvd;
    logic mp_fmt;
    logic two_stop;
    logic par_odd;
    logic par_en;
    logic sync_mode;
    logic rx_enable;
    logic tx_enable;
  } ssf_ctrl_s;

  // One finished character as the receive shifter hands it over
  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       stop1;
    logic       stop2;
    logic       received_multiproc_bit;
  } ssf_rx_char_s;

endpackage
`default_nettype wire

// ### ssf_flag_cell.sv
`default_nettype none
// One clearable status flag with its read-before-clear memory
module ssf_flag_cell
  import ssf_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // Clock and initialisation
  input  wire logic ref_clk_i,
  input  wire logic init_i,
  input  wire logic ce_i,
  // Hardware side
  input  wire logic set_i,
  input  wire logic force_i,
  // Software side
  input  wire logic rd_i,
  input  wire logic clr_i,
  // State
  output logic      flag_o,
  output logic      armed_o
);

  // Set or force beats a clear arriving in the same cycle
  // clear needs prior read
  always_ff @(posedge ref_clk_i)
  begin
    if (init_i)
      flag_o <= RESET_VAL;
    else if (ce_i)
    begin
      if (set_i || force_i)
        flag_o <= 1'b1;
      else if (clr_i && armed_o)
        flag_o <= 1'b0;
    end
  end

  // Armed once read as 1; a fresh set must be read again
  always_ff @(posedge ref_clk_i)
  begin
    if (init_i)
      armed_o <= 1'b0;
    else if (ce_i)
    begin
      if (set_i || force_i)
        armed_o <= 1'b0;
      else if (clr_i && armed_o)
        armed_o <= 1'b0;
      else if (rd_i && flag_o)
        armed_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### ssf_status_flags.sv
// Contract
// - Status register initialises to 84 hex
// - Transmit complete and multiproc bit read-only
// - Buffer empty sets on shifter load
// - Buffer empty forced by reset, transmit disable
// - Buffer empty clears by read-write-0
// - Buffer full sets on clean receive
// - Buffer full clears by reset, sequence
// - Overrun, receive disable leave data alone
// - Overrun when full flag still set
// - Overrun halts receive, sync transmit too
// - Overrun clears by reset, sequence only
// - Framing error on zero stop bit
// - Only first stop bit checked
// - Framing error copies data, no full
// - Framing error halts reception
// - Framing error clears by reset, sequence
// - Parity error on parity mismatch
// - Transmit complete sets at idle, reset
// - Transmit complete clears with buffer empty
`default_nettype none
module ssf_status_flags
  import ssf_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // Power-down states
  input  wire logic               standby_i,
  input  wire logic               module_standby_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [WB_DW-1:0]   wb_dat_i,
  output logic      [WB_DW-1:0]   wb_dat_o,
  output logic                    wb_ack_o,
  // Transmit shifter events
  input  wire logic               tx_load_i,
  input  wire logic               tx_last_bit_i,
  // Receive shifter events
  input  wire logic               rx_done_i,
  input  wire ssf_rx_char_s       rx_char_i,
  // To the shifters
  output ssf_ctrl_s               ctrl_o,
  output logic      [7:0]         tx_data_o,
  output logic                    tx_mpb_o,
  output logic                    rx_halt_o,
  output logic                    tx_halt_o,
  // Observed state
  output logic      [7:0]         rx_data_o,
  output logic      [7:0]         status_o
);

  // True when the received parity bit disagrees with the setting
  function automatic logic parity_bad(input logic [7:0] d,
                                      input logic p,
                                      input logic odd);
    parity_bad = ((^d) ^ p) != odd;
  endfunction

  // True when a byte address decodes to the given register
  function automatic logic hit(input logic [ADR_W-1:0] a,
                               input logic [ADR_W-1:0] r);
    hit = (a == r);
  endfunction

  // Initialisation: reset, standby and module standby alike
  logic               init;
  // Bus request taken this cycle
  logic               take;
  logic               wr_lane;
  // Status access strobes
  logic               rd_stat;
  logic               wr_stat;
  // Per-flag hardware and software inputs
  logic [NFLAG-1:0]   set_v;
  logic [NFLAG-1:0]   force_v;
  logic [NFLAG-1:0]   clr_v;
  logic [NFLAG-1:0]   flag_v;
  logic [NFLAG-1:0]   armed_v;
  // Receive outcome of the current character
  logic               rx_accept;
  logic               rx_ovr;
  logic               rx_fer;
  logic               rx_per;
  logic               rx_good;
  logic               rx_copy;
  // Receive is blocked while any error flag stands
  logic               rx_blocked;
  // Transmit-empty clear that really takes effect
  logic               txe_cleared;
  // Register state
  logic               tx_complete_q;
  logic               mpb_q;
  logic               multiproc_bit_to_send_q;
  logic [7:0]         rx_data_q;
  logic [7:0]         tx_data_q;
  ssf_ctrl_s          ctrl_q;
  logic               ack_q;
  logic [WB_DW-1:0]   dat_q;
  logic [7:0]         status;

  // Standby states act exactly like a reset of this block
  // all init sources
  assign init = rst_i | standby_i | module_standby_i;

  // Classic cycle: one take per request, ack drops the next cycle
  assign take    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lane = take & wb_we_i & wb_sel_i[LANE0];
  assign rd_stat = take & ~wb_we_i & hit(wb_adr_i, ADR_STATUS);
  assign wr_stat = wr_lane & hit(wb_adr_i, ADR_STATUS);

  // Assembled status byte
  always_comb
  begin
    status           = 8'h00;
    status[BIT_TXE]  = flag_v[F_TXE];
    status[BIT_RXF]  = flag_v[F_RXF];
    status[BIT_OVR]  = flag_v[F_OVR];
    status[BIT_FER]  = flag_v[F_FER];
    status[BIT_PER]  = flag_v[F_PER];
    status[BIT_TX_COMPLETE] = tx_complete_q;
    status[BIT_MPB]  = mpb_q;
    status[BIT_MULTIPROC_BIT_TO_SEND] = multiproc_bit_to_send_q;
  end

  // Any standing error stops the receiver
  // overrun halts
  assign rx_blocked = flag_v[F_OVR] | flag_v[F_FER] | flag_v[F_PER];

  // Characters are dropped while disabled or halted
  assign rx_accept = rx_done_i & ctrl_q.rx_enable & ~rx_blocked;

  // Classify a finished character; overrun has priority
  always_comb
  begin
    rx_ovr  = 1'b0;
    rx_fer  = 1'b0;
    rx_per  = 1'b0;
    rx_good = 1'b0;
    rx_copy = 1'b0;
    if (rx_accept)
    begin
      if (flag_v[F_RXF])
        rx_ovr = 1'b1;
      else if (!ctrl_q.sync_mode && !rx_char_i.stop1)
      begin
        rx_fer  = 1'b1;
        rx_copy = 1'b1;
      end
      else if (!ctrl_q.sync_mode && ctrl_q.par_en &&
               parity_bad(rx_char_i.data, rx_char_i.parity, ctrl_q.par_odd))
      begin
        rx_per  = 1'b1;
        rx_copy = 1'b1;
      end
      else
      begin
        rx_good = 1'b1;
        rx_copy = 1'b1;
      end
    end
  end

  // Hardware set and force terms of the five flags
  always_comb
  begin
    set_v          = '0;
    force_v        = '0;
    set_v[F_TXE]   = tx_load_i;
    force_v[F_TXE] = ~ctrl_q.tx_enable;
    set_v[F_RXF]   = rx_good;
    set_v[F_OVR]   = rx_ovr;
    set_v[F_FER]   = rx_fer;
    set_v[F_PER]   = rx_per;
  end

  // A 0 written into a flag's position requests its clear
  // zero-write clear only
  always_comb
  begin
    clr_v = '0;
    for (int i = 0; i < NFLAG; i++)
      clr_v[i] = wr_stat & ~wb_dat_i[FLAG_LSB + i];
  end

  // The five clearable flags
  // sequence clears empty
  for (genvar g = 0; g < NFLAG; g++)
  begin : g_flag
    ssf_flag_cell #(
      .RESET_VAL (STATUS_RESET[FLAG_LSB + g])
    ) u_cell (
      .ref_clk_i (ref_clk_i),
      .init_i    (init),
      .ce_i      (ce_i),
      .set_i     (set_v[g]),
      .force_i   (force_v[g]),
      .rd_i      (rd_stat),
      .clr_i     (clr_v[g]),
      .flag_o    (flag_v[g]),
      .armed_o   (armed_v[g])
    );
  end

  // Mirrors the cell: a clear that no set or force overrides
  assign txe_cleared = clr_v[F_TXE] & armed_v[F_TXE] &
                       ~set_v[F_TXE] & ~force_v[F_TXE];

  // Transmit complete: read-only, follows the empty flag's clear
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      tx_complete_q <= STATUS_RESET[BIT_TX_COMPLETE];
    else if (ce_i)
    begin
      if (!ctrl_q.tx_enable || (tx_last_bit_i && flag_v[F_TXE]))
        tx_complete_q <= 1'b1;
      else if (txe_cleared)
        tx_complete_q <= 1'b0;
    end
  end

  // Received multiprocessor bit, kept when receive is disabled
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      mpb_q <= STATUS_RESET[BIT_MPB];
    else if (ce_i && rx_good && ctrl_q.mp_fmt && !ctrl_q.sync_mode)
      mpb_q <= rx_char_i.received_multiproc_bit;
  end

  // Multiprocessor bit to send: the only plain writable status bit
  // read-only bits skipped
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      multiproc_bit_to_send_q <= STATUS_RESET[BIT_MULTIPROC_BIT_TO_SEND];
    else if (ce_i && wr_stat)
      multiproc_bit_to_send_q <= wb_dat_i[BIT_MULTIPROC_BIT_TO_SEND];
  end

  // Receive data only moves on a copy; overrun, halt and disable leave it
  // data held otherwise
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      rx_data_q <= DATA_RESET;
    else if (ce_i && rx_copy)
      rx_data_q <= rx_char_i.data;
  end

  // Transmit data written by software
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      tx_data_q <= DATA_RESET;
    else if (ce_i && wr_lane && hit(wb_adr_i, ADR_TXDATA))
      tx_data_q <= wb_dat_i[7:0];
  end

  // Control register; the reserved bit never stores
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      ctrl_q <= CTRL_RESET;
    else if (ce_i && wr_lane && hit(wb_adr_i, ADR_CTRL))
    begin
      ctrl_q      <= wb_dat_i[7:0];
      ctrl_q.rsvd <= 1'b0;
    end
  end

  // Bus answer: one wait-free cycle after the take
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      ack_q <= 1'b0;
    else if (ce_i)
      ack_q <= take;
  end

  // Read data; unmapped offsets answer with zero
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      dat_q <= '0;
    else if (ce_i && take)
    begin
      dat_q <= '0;
      if (!wb_we_i)
      begin
        case (wb_adr_i)
          ADR_STATUS: dat_q[7:0] <= status;
          ADR_CTRL:   dat_q[7:0] <= ctrl_q;
          ADR_RXDATA: dat_q[7:0] <= rx_data_q;
          ADR_TXDATA: dat_q[7:0] <= tx_data_q;
          default:    dat_q      <= '0;
        endcase
      end
    end
  end

  // Halt levels to the shifters, one cycle behind the flags
  // sync transmit stops
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
    begin
      rx_halt_o <= 1'b0;
      tx_halt_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_halt_o <= rx_blocked;
      tx_halt_o <= ctrl_q.sync_mode & rx_blocked;
    end
  end

  // Status mirror for observation, also a flip-flop
  always_ff @(posedge ref_clk_i)
  begin
    if (init)
      status_o <= STATUS_RESET;
    else if (ce_i)
      status_o <= status;
  end

  // Outputs taken straight from their registers
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;
  assign ctrl_o    = ctrl_q;
  assign tx_data_o = tx_data_q;
  assign tx_mpb_o  = multiproc_bit_to_send_q;
  assign rx_data_o = rx_data_q;

endmodule
`default_nettype wire

// ### ssf_status_assertions.sv
`default_nettype none
// Port-level checks of the status flag block
module ssf_status_assertions
  import ssf_pkg::*;
(
  // Clock and init
  input wire logic             ref_clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             standby_i,
  input wire logic             module_standby_i,
  // Bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic             wb_ack_o,
  // Shifter side and state
  input wire logic             tx_load_i,
  input wire logic             rx_done_i,
  input wire ssf_rx_char_s     rx_char_i,
  input wire ssf_ctrl_s        ctrl_o,
  input wire logic             rx_halt_o,
  input wire logic [7:0]       rx_data_o,
  input wire logic [7:0]       status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Request taken at this edge
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // Character arrives while no error halts; bus quiet so status_o is current
  sequence s_rx_free;
    rx_done_i && ce_i && ctrl_o.rx_enable && !wb_ack_o && status_o[5:3] == 3'h0;
  endsequence
  a_standby_init: assert property
    ((standby_i || module_standby_i) |=> status_o == STATUS_RESET) else $error("bad init");
  a_rx_data_hold: assert property
    (!rx_done_i && !standby_i && !module_standby_i |=> $stable(rx_data_o))
    else $error("rx data moved");
  a_overrun_keep: assert property
    (s_rx_free ##0 status_o[BIT_RXF] |=> $stable(rx_data_o) ##1 status_o[BIT_OVR])
    else $error("overrun wrong");
  a_frame_copy: assert property
    (s_rx_free ##0 (!status_o[BIT_RXF] && !ctrl_o.sync_mode && !rx_char_i.stop1)
     |=> rx_data_o == $past(rx_char_i.data) ##1 (status_o[BIT_FER] && !status_o[BIT_RXF]))
    else $error("framing wrong");
  a_second_stop: assert property
    (s_rx_free ##0 (!status_o[BIT_RXF] && !ctrl_o.sync_mode && !ctrl_o.par_en
     && rx_char_i.stop1) |=> ##1 (status_o[BIT_RXF] && !status_o[BIT_FER]))
    else $error("clean char wrong");
  a_txe_on_load: assert property
    (tx_load_i && ce_i ##1 ce_i |=> status_o[BIT_TXE]) else $error("empty not set");
  a_tx_complete_with_txe: assert property
    ($fell(status_o[BIT_TX_COMPLETE]) |-> $fell(status_o[BIT_TXE])) else $error("tx_complete fell alone");
  a_write_no_set: assert property
    (s_take ##0 (wb_we_i && wb_adr_i == ADR_STATUS && status_o[6:3] == 4'h0
     && !rx_done_i && !$past(rx_done_i)) |=> ##1 status_o[6:3] == 4'h0)
    else $error("write set a flag");
  a_rx_halt: assert property
    (status_o[5:3] != 3'h0 |-> ##[0:1] rx_halt_o) else $error("no rx halt");
endmodule
bind ssf_status_flags ssf_status_assertions i_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .standby_i(standby_i),
  .module_standby_i(module_standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .tx_load_i(tx_load_i),
  .rx_done_i(rx_done_i), .rx_char_i(rx_char_i), .ctrl_o(ctrl_o), .rx_halt_o(rx_halt_o),
  .rx_data_o(rx_data_o), .status_o(status_o)
);
`default_nettype wire

// ### ssf_shifter_model.sv
`default_nettype none
// Stands in for the transmit and receive shifters
module ssf_shifter_model
  import ssf_pkg::*;
(
  input  wire logic     ref_clk_i,
  output logic          tx_load_o,
  output logic          tx_last_o,
  output logic          rx_done_o,
  output ssf_rx_char_s  rx_char_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial
  begin
    tx_load_o = 1'b0;
    tx_last_o = 1'b0;
    rx_done_o = 1'b0;
    rx_char_o = '0;
  end
  // One finished character; afterwards the data lines scramble so no stale value helps
  task automatic rx(input ssf_rx_char_s c);
    @(posedge ref_clk_i);
    rx_done_o <= 1'b1;
    rx_char_o <= c;
    @(posedge ref_clk_i);
    rx_done_o <= 1'b0;
    rx_char_o <= ~c;
  endtask
  // Transmit event pulse: shifter load when ld, else last bit sent
  task automatic tx(input logic ld);
    @(posedge ref_clk_i);
    tx_load_o <= ld;
    tx_last_o <= !ld;
    @(posedge ref_clk_i);
    tx_load_o <= 1'b0;
    tx_last_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench
  import ssf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         ref_clk, rst, mstby, cyc, stb, we, ack, ld, lst, dn, rx_halt, tx_halt;
  logic         ce, stby, mpb_out;
  logic [3:0]   adr;
  // Byte lanes of the next request, copied onto the bus by the bus task
  logic [3:0]   sel, lane;
  logic [31:0]  wdat, rdat;
  logic [7:0]   rxd, status, got, txd;
  ssf_ctrl_s    ctrl;
  ssf_rx_char_s ch;
  int           fails, checks_done, cycles;
  // 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ssf_status_flags i_dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce), .standby_i(stby),
    .module_standby_i(mstby), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_load_i(ld), .tx_last_bit_i(lst), .rx_done_i(dn), .rx_char_i(ch), .ctrl_o(ctrl),
    .tx_data_o(txd), .tx_mpb_o(mpb_out), .rx_halt_o(rx_halt), .tx_halt_o(tx_halt),
    .rx_data_o(rxd), .status_o(status)
  );
  ssf_shifter_model i_far (
    .ref_clk_i(ref_clk), .tx_load_o(ld), .tx_last_o(lst), .rx_done_o(dn), .rx_char_o(ch)
  );
  // Compare one byte
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Classic cycle held until ack is sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge ref_clk iff ack);
    got = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, e);
  endtask
  // Character with {parity, stop1, stop2}
  function automatic ssf_rx_char_s mk(input logic [7:0] d, input logic [2:0] f);
    return {d, f, 1'b0};
  endfunction
  // Initial values, clear without read, write of ones, transmit flags, standby
  task automatic t_tx();
    rd(ADR_CTRL, CTRL_RESET);
    rd(4'h1, 8'h00);
    bus(1'b1, ADR_CTRL, 8'h01);
    bus(1'b1, ADR_STATUS, 8'h00);
    rd(ADR_STATUS, STATUS_RESET);
    bus(1'b1, ADR_STATUS, 8'hFF);
    rd(ADR_STATUS, 8'h85);
    bus(1'b1, ADR_STATUS, 8'h00);
    rd(ADR_STATUS, 8'h00);
    i_far.tx(1'b0);
    rd(ADR_STATUS, 8'h00);
    i_far.tx(1'b1);
    rd(ADR_STATUS, 8'h80);
    i_far.tx(1'b0);
    rd(ADR_STATUS, 8'h84);
    bus(1'b1, ADR_STATUS, 8'h01);
    bus(1'b1, ADR_CTRL, 8'h00);
    rd(ADR_STATUS, 8'h85);
    mstby <= 1'b1;
    @(posedge ref_clk);
    mstby <= 1'b0;
    rd(ADR_STATUS, STATUS_RESET);
  endtask
  // Full, overrun, halts, clearing
  task automatic t_rx();
    bus(1'b1, ADR_CTRL, 8'h02);
    i_far.rx(mk(8'hA5, 3'h3));
    rd(ADR_STATUS, 8'hC4);
    i_far.rx(mk(8'h3C, 3'h3));
    rd(ADR_STATUS, 8'hE4);
    i_far.rx(mk(8'h5A, 3'h3));
    rd(ADR_RXDATA, 8'hA5);
    chk({7'h0, rx_halt}, 8'h01);
    bus(1'b1, ADR_CTRL, 8'h06);
    repeat (2) @(posedge ref_clk);
    chk({7'h0, tx_halt}, 8'h01);
    bus(1'b1, ADR_CTRL, 8'h00);
    rd(ADR_STATUS, 8'hE4);
    bus(1'b1, ADR_STATUS, 8'h80);
    rd(ADR_STATUS, 8'h84);
  endtask
  // Two stop bits, framing error, parity error
  task automatic t_frame();
    bus(1'b1, ADR_CTRL, 8'h22);
    i_far.rx(mk(8'h11, 3'h2));
    rd(ADR_STATUS, 8'hC4);
    bus(1'b1, ADR_STATUS, 8'h80);
    i_far.rx(mk(8'h96, 3'h1));
    rd(ADR_STATUS, 8'h94);
    i_far.rx(mk(8'h33, 3'h3));
    rd(ADR_RXDATA, 8'h96);
    bus(1'b1, ADR_CTRL, 8'h20);
    rd(ADR_STATUS, 8'h94);
    bus(1'b1, ADR_STATUS, 8'h80);
    rd(ADR_STATUS, 8'h84);
    bus(1'b1, ADR_CTRL, 8'h2A);
    i_far.rx(mk(8'h01, 3'h3));
    rd(ADR_STATUS, 8'h8C);
  endtask
  // Lane select, odd parity, multiproc bits, transmit data, clock enable, standby
  task automatic t_more();
    lane = 4'hE;
    bus(1'b1, ADR_STATUS, 8'h01);
    lane = 4'hF;
    rd(ADR_STATUS, 8'h8C);
    bus(1'b1, ADR_STATUS, 8'h80);
    bus(1'b1, ADR_CTRL, 8'h5B);
    i_far.rx({8'h01, 1'b0, 1'b1, 1'b0, 1'b1});
    rd(ADR_STATUS, 8'hC6);
    chk(rxd, 8'h01);
    bus(1'b1, ADR_STATUS, 8'hFF);
    rd(ADR_STATUS, 8'hC7);
    chk({7'h0, mpb_out}, 8'h01);
    bus(1'b1, ADR_TXDATA, 8'h5C);
    chk(txd, 8'h5C);
    bus(1'b1, ADR_STATUS, 8'h7F);
    rd(ADR_STATUS, 8'h43);
    // A load pulse while the clock enable is low must leave the flags frozen
    ce <= 1'b0;
    i_far.tx(1'b1);
    ce <= 1'b1;
    rd(ADR_STATUS, 8'h43);
    stby <= 1'b1;
    @(posedge ref_clk);
    stby <= 1'b0;
    rd(ADR_STATUS, STATUS_RESET);
    chk({7'h0, mpb_out}, 8'h00);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far above the some 175 cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      close_out();
    end
  end
  // Reset for two cycles, then the scenarios
  initial
  begin
    rst = 1'b1;
    mstby = 1'b0;
    ce = 1'b1;
    stby = 1'b0;
    sel = 4'hF;
    lane = 4'hF;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_tx();
    t_rx();
    t_frame();
    t_more();
    close_out();
  end
endmodule
`default_nettype wire
